// ---- logic/dsp_mem_pkg.sv ----
/*
 * Shared constants, address map, mode codes and state layout of the core memory set.
 * Assumes one core clock and a synchronous active-high reset.
 */
package dsp_mem_pkg;
    // ============================================================
    // Widths
    localparam int          DATA_W           = 24;
    localparam int          ADDR_W           = 16;

    // ============================================================
    // Address map, each space decoded into disjoint windows
    localparam logic [15:0] X_COEFF_RAM_BASE        = 16'h0000;
    localparam logic [15:0] Y_COEFF_RAM_BASE        = 16'h0000;
    localparam logic [15:0] CRAM_DEPTH       = 16'h0200;
    localparam logic [15:0] X_DATA_ROM_BASE        = 16'h0200;
    localparam logic [15:0] Y_DATA_ROM_BASE        = 16'h0200;
    localparam logic [15:0] DROM_DEPTH       = 16'h0100;
    localparam logic [15:0] PROGRAM_RAM_BASE        = 16'h0000;
    localparam logic [15:0] PROGRAM_RAM_DEPTH_CORE0 = 16'h0400;
    localparam logic [15:0] PROGRAM_RAM_DEPTH_CORE1 = 16'h1600;
    localparam logic [15:0] BOOT_BASE        = 16'hFF80;
    localparam logic [15:0] BOOT_DEPTH       = 16'h0080;

    // ============================================================
    // Operating mode
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b01,
        MODE_BOOT   = 2'b10
    } mode_e;
    localparam mode_e       MODE_RESET       = MODE_BOOT;
    localparam int          MODE_BOOT_BIT    = 1;
    localparam logic [23:0] DATA_RESET       = 24'h000000;

    // ============================================================
    // State of the top module
    typedef struct packed {
        mode_e       mode;
        logic [23:0] x_data;
        logic        x_valid;
        logic [23:0] y_data;
        logic        y_valid;
        logic [23:0] p_data;
        logic        fetch_valid;
        logic        move_valid;
    } state_s;

    // ============================================================
    // Window decode
    function automatic logic in_range(input logic [15:0] addr,
                                      input logic [15:0] base,
                                      input logic [15:0] depth);
        logic [15:0] offs;
        offs = addr - base;
        return (addr >= base) && (offs < depth);
    endfunction
endpackage

// ---- logic/ram_port_if.sv ----
/*
 * Single-port RAM access bundle between the memory set and its arrays.
 * Assumes the controller drives every request signal each cycle.
 */
`timescale 1ns/10ps
interface ram_port_if;
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [23:0] wdata;
    logic [23:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface

// ---- logic/spram_array.sv ----
/*
 * Single-port 24-bit RAM array, clocked write, combinational read.
 * Assumes the caller registers the read word; out-of-range reads give zero.
 */
`timescale 1ns/10ps
module spram_array #(
    parameter int DEPTH = 512
) (
    input  wire logic  i_clk,
    input  wire logic  i_ce,
    ram_port_if.mem    port
);
    localparam int          AW  = $clog2(DEPTH);
    localparam logic [15:0] LIM = 16'(DEPTH);

    logic [23:0] mem [DEPTH];
    logic        hit;

    assign hit = port.addr < LIM;

    // ============================================================
    // Storage, no reset: contents are loaded by software
    always_ff @(posedge i_clk) begin
        if (i_ce && port.en && port.we && hit) begin
            mem[port.addr[AW-1:0]] <= port.wdata;
        end
    end

    assign port.rdata = hit ? mem[port.addr[AW-1:0]] : '0;
endmodule

// ---- logic/dsp_core_memory_subsystem.sv ----
/*
 * Memory set of one signal-processor core: X and Y coefficient RAMs, X and Y data ROMs,
 * program RAM, boot ROM and the operating mode bit.
 * Assumes requests come from address generators on the same clock; reads answer one cycle later.
 */
// What this block does
// - Per-core identical set; program RAM depth per core
// - X RAM 512x24, 16-bit address
// - X data also serves the bus switch
// - Y RAM 512x24, 16-bit address
// - Y data also serves the bus switch
// - Program address: fetch generator or move instruction
// - Program RAM written only by move instruction
// - Fetched word goes to decode controller
// - X ROM 256x24 drives only in range
// - Y ROM 256x24 drives only in range
// - Boot ROM 128x24 holds the loader
// - One mode bit: boot or normal
// - Core reset forces boot mode
`timescale 1ns/10ps
module dsp_core_memory_subsystem #(
    parameter int          CORE_ID          = 0,
    parameter logic [23:0] X_ROM_IMAGE [256] = '{default: 24'h000000},
    parameter logic [23:0] Y_ROM_IMAGE [256] = '{default: 24'h000000},
    parameter logic [23:0] BOOT_IMAGE  [128] = '{default: 24'h000000}
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_ce,
    input  wire logic [15:0] i_x_address_bus,
    input  wire logic        i_x_rd,
    input  wire logic        i_x_wr,
    input  wire logic [23:0] i_x_data_bus,
    output logic      [23:0] o_x_data_bus,
    output logic             o_x_data_valid,
    input  wire logic [15:0] i_y_address_bus,
    input  wire logic        i_y_rd,
    input  wire logic        i_y_wr,
    input  wire logic [23:0] i_y_data_bus,
    output logic      [23:0] o_y_data_bus,
    output logic             o_y_data_valid,
    input  wire logic        i_fetch,
    input  wire logic [15:0] i_program_address_bus,
    input  wire logic        i_move_to_program_memory_instr,
    input  wire logic        i_move_wr,
    input  wire logic [15:0] i_move_address,
    input  wire logic [23:0] i_move_data,
    output logic      [23:0] o_program_data_bus,
    output logic             o_fetch_valid,
    output logic             o_move_valid,
    input  wire logic        i_core_reset_bit,
    input  wire logic        i_mode_clear,
    output logic             o_boot_mode
);
    import dsp_mem_pkg::*;

    // Program RAM depth is the only difference between the two cores
    localparam logic [15:0] PROGRAM_RAM_DEPTH = (CORE_ID == 0) ? PROGRAM_RAM_DEPTH_CORE0 : PROGRAM_RAM_DEPTH_CORE1;
    localparam int          PROGRAM_RAM_WORDS = int'(PROGRAM_RAM_DEPTH);

    state_s state_r;
    state_s state_nxt;

    ram_port_if x_port ();
    ram_port_if y_port ();
    ram_port_if p_port ();

    logic x_coeff_ram_hit;
    logic x_data_rom_hit;
    logic y_coeff_ram_hit;
    logic y_data_rom_hit;
    logic program_ram_hit;
    logic boot_hit;
    logic move_go;
    logic fetch_go;

    // ============================================================
    // Address decode
    assign x_coeff_ram_hit = in_range(i_x_address_bus, X_COEFF_RAM_BASE, CRAM_DEPTH);
    assign x_data_rom_hit = in_range(i_x_address_bus, X_DATA_ROM_BASE, DROM_DEPTH);
    assign y_coeff_ram_hit = in_range(i_y_address_bus, Y_COEFF_RAM_BASE, CRAM_DEPTH);
    assign y_data_rom_hit = in_range(i_y_address_bus, Y_DATA_ROM_BASE, DROM_DEPTH);
    assign move_go  = i_move_to_program_memory_instr;
    assign fetch_go = i_fetch && !move_go;
    // A move instruction stalls the fetch, so it owns the single program port
    assign program_ram_hit = in_range(move_go ? i_move_address : i_program_address_bus,
                               PROGRAM_RAM_BASE, PROGRAM_RAM_DEPTH);
    assign boot_hit = in_range(i_program_address_bus, BOOT_BASE, BOOT_DEPTH);

    // ============================================================
    // RAM ports
    assign x_port.en    = x_coeff_ram_hit && (i_x_rd || i_x_wr);
    assign x_port.we    = i_x_wr;
    assign x_port.addr  = i_x_address_bus - X_COEFF_RAM_BASE;
    assign x_port.wdata = i_x_data_bus;
    assign y_port.en    = y_coeff_ram_hit && (i_y_rd || i_y_wr);
    assign y_port.we    = i_y_wr;
    assign y_port.addr  = i_y_address_bus - Y_COEFF_RAM_BASE;
    assign y_port.wdata = i_y_data_bus;
    assign p_port.en    = program_ram_hit && (move_go || i_fetch);
    assign p_port.we    = move_go && i_move_wr;
    assign p_port.addr  = (move_go ? i_move_address : i_program_address_bus) - PROGRAM_RAM_BASE;
    assign p_port.wdata = i_move_data;

    spram_array #(.DEPTH(int'(CRAM_DEPTH))) u_x_coeff_ram (
        .i_clk (i_clk),
        .i_ce  (i_ce),
        .port  (x_port)
    );
    spram_array #(.DEPTH(int'(CRAM_DEPTH))) u_y_coeff_ram (
        .i_clk (i_clk),
        .i_ce  (i_ce),
        .port  (y_port)
    );
    spram_array #(.DEPTH(PROGRAM_RAM_WORDS)) u_program_ram (
        .i_clk (i_clk),
        .i_ce  (i_ce),
        .port  (p_port)
    );

    // ============================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.x_valid     = 1'b0;
        state_nxt.y_valid     = 1'b0;
        state_nxt.fetch_valid = 1'b0;
        state_nxt.move_valid  = 1'b0;
        // X bus: RAM or ROM word, also seen by the bus switch
        if (i_x_rd && !i_x_wr && x_coeff_ram_hit) begin
            state_nxt.x_data  = x_port.rdata;
            state_nxt.x_valid = 1'b1;
        end else if (i_x_rd && x_data_rom_hit) begin
            state_nxt.x_data  = X_ROM_IMAGE[i_x_address_bus[7:0]];
            state_nxt.x_valid = 1'b1;
        end
        if (i_y_rd && !i_y_wr && y_coeff_ram_hit) begin
            state_nxt.y_data  = y_port.rdata;
            state_nxt.y_valid = 1'b1;
        end else if (i_y_rd && y_data_rom_hit) begin
            state_nxt.y_data  = Y_ROM_IMAGE[i_y_address_bus[7:0]];
            state_nxt.y_valid = 1'b1;
        end
        // Program bus: move reads program RAM in any mode; fetch reads boot ROM in boot mode, program RAM otherwise
        if (move_go && !i_move_wr && program_ram_hit) begin
            state_nxt.p_data     = p_port.rdata;
            state_nxt.move_valid = 1'b1;
        end else if (fetch_go && state_r.mode == MODE_BOOT && boot_hit) begin
            state_nxt.p_data      = BOOT_IMAGE[i_program_address_bus[6:0]];
            state_nxt.fetch_valid = 1'b1;
        end else if (fetch_go && state_r.mode == MODE_NORMAL && program_ram_hit) begin
            state_nxt.p_data      = p_port.rdata;
            state_nxt.fetch_valid = 1'b1;
        end
        // Core reset beats the loader's clear in the same cycle
        if (i_core_reset_bit) begin
            state_nxt.mode = MODE_BOOT;
        end else if (i_mode_clear) begin
            state_nxt.mode = MODE_NORMAL;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= '{mode: MODE_RESET, x_data: DATA_RESET, x_valid: 1'b0, y_data: DATA_RESET,
                         y_valid: 1'b0, p_data: DATA_RESET, fetch_valid: 1'b0, move_valid: 1'b0};
        end else if (i_ce) begin
            state_r <= state_nxt;
        end
    end

    assign o_x_data_bus       = state_r.x_data;
    assign o_x_data_valid     = state_r.x_valid;
    assign o_y_data_bus       = state_r.y_data;
    assign o_y_data_valid     = state_r.y_valid;
    assign o_program_data_bus = state_r.p_data;
    assign o_fetch_valid      = state_r.fetch_valid;
    assign o_move_valid       = state_r.move_valid;
    assign o_boot_mode        = state_r.mode[MODE_BOOT_BIT];

    // ============================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    property p_x_readback;
        (i_ce && i_x_wr && x_coeff_ram_hit) ##1 (i_ce && i_x_rd && !i_x_wr && i_x_address_bus == $past(i_x_address_bus))
        |=> (o_x_data_valid && o_x_data_bus == $past(i_x_data_bus, 2));
    endproperty
    a_x_readback: assert property (p_x_readback) else $error("X RAM readback mismatch");

    property p_x_switch_valid;
        (i_ce && i_x_rd && (x_coeff_ram_hit || x_data_rom_hit)) |=> o_x_data_valid;
    endproperty
    a_x_switch_valid: assert property (p_x_switch_valid) else $error("X read not driven");

    property p_y_readback;
        (i_ce && i_y_wr && y_coeff_ram_hit) ##1 (i_ce && i_y_rd && !i_y_wr && i_y_address_bus == $past(i_y_address_bus))
        |=> (o_y_data_valid && o_y_data_bus == $past(i_y_data_bus, 2));
    endproperty
    a_y_readback: assert property (p_y_readback) else $error("Y RAM readback mismatch");

    property p_y_switch_valid;
        (i_ce && i_y_rd && (y_coeff_ram_hit || y_data_rom_hit)) |=> o_y_data_valid;
    endproperty
    a_y_switch_valid: assert property (p_y_switch_valid) else $error("Y read not driven");

    property p_fetch_addr;
        (fetch_go && p_port.en) |-> (p_port.addr == i_program_address_bus - PROGRAM_RAM_BASE && !p_port.we);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("Fetch address not from generator");

    property p_program_ram_write_src;
        p_port.we && p_port.en |-> (move_go && i_move_wr && p_port.addr < PROGRAM_RAM_DEPTH);
    endproperty
    a_program_ram_write_src: assert property (p_program_ram_write_src) else $error("Program RAM write outside move");

    property p_fetch_decode;
        (i_ce && fetch_go && !o_boot_mode && program_ram_hit) |=> (o_fetch_valid && !o_move_valid);
    endproperty
    a_fetch_decode: assert property (p_fetch_decode) else $error("Fetched word not delivered");

    property p_x_data_rom_range;
        (i_ce && i_x_rd && !x_coeff_ram_hit && !x_data_rom_hit) |=> !o_x_data_valid;
    endproperty
    a_x_data_rom_range: assert property (p_x_data_rom_range) else $error("X bus driven out of range");

    property p_y_data_rom_data;
        (i_ce && i_y_rd && y_data_rom_hit) |=> (o_y_data_bus == Y_ROM_IMAGE[$past(i_y_address_bus[7:0])]);
    endproperty
    a_y_data_rom_data: assert property (p_y_data_rom_data) else $error("Y ROM word wrong");

    property p_boot_fetch;
        (i_ce && fetch_go && o_boot_mode && boot_hit)
        |=> (o_fetch_valid && o_program_data_bus == BOOT_IMAGE[$past(i_program_address_bus[6:0])]);
    endproperty
    a_boot_fetch: assert property (p_boot_fetch) else $error("Boot ROM word wrong");

    property p_mode_clear;
        (i_ce && i_mode_clear && !i_core_reset_bit) |=> !o_boot_mode ##1 (o_boot_mode == $past(i_ce && i_core_reset_bit));
    endproperty
    a_mode_clear: assert property (p_mode_clear) else $error("Mode bit did not clear");

    property p_reset_boot;
        (i_ce && i_core_reset_bit) |=> o_boot_mode;
    endproperty
    a_reset_boot: assert property (p_reset_boot) else $error("Core reset did not force boot mode");

    property p_one_driver;
        $onehot0({x_coeff_ram_hit, x_data_rom_hit}) && $onehot0({y_coeff_ram_hit, y_data_rom_hit}) && !(program_ram_hit && boot_hit && !move_go);
    endproperty
    a_one_driver: assert property (p_one_driver) else $error("Overlapping memory windows");

    c_boot_fetch:  cover property (i_ce && fetch_go && o_boot_mode && boot_hit ##1 o_fetch_valid);
    c_move_write:  cover property (i_ce && move_go && i_move_wr && program_ram_hit);
    c_leave_boot:  cover property (o_boot_mode ##1 !o_boot_mode);
    c_x_data_rom_read:   cover property (i_ce && i_x_rd && x_data_rom_hit ##1 o_x_data_valid);
endmodule

// ---- sim/core_loader_model.sv ----
/*
 * Model of the core-side boot loader that ends boot by clearing the mode bit.
 * Assumes one core clock; i_start is a one-cycle pulse, i_delay sets how long loading takes.
 */
`timescale 1ns/10ps
module core_loader_model (
    input  wire logic       i_clk,
    input  wire logic       i_start,
    input  wire logic [3:0] i_delay,
    output logic            o_mode_clear
);
    // ============================================================
    // Loader
    logic [4:0] left_r = 5'h00;
    initial o_mode_clear = 1'b0;
    // Large delays stand for a slow image download before the clear
    always @(posedge i_clk) begin
        o_mode_clear <= 1'b0;
        if (i_start) begin
            left_r <= {1'b0, i_delay} + 5'h01;
        end else if (left_r == 5'h01) begin
            left_r       <= 5'h00;
            o_mode_clear <= 1'b1;
        end else if (left_r != 5'h00) begin
            left_r <= left_r - 5'h01;
        end
    end
endmodule

// ---- sim/dsp_core_memory_subsystem_test.sv ----
/*
 * Self-checking bench of one core's memory set: X/Y RAM and ROM, program RAM, boot ROM, mode bit.
 * Assumes core 0 (1024-word program RAM); ROM images are built by rom_word.
 */
`timescale 1ns/10ps
module dsp_core_memory_subsystem_test;
    import dsp_mem_pkg::*;
    typedef logic [23:0] w256_t [256];
    typedef logic [23:0] w128_t [128];
    localparam logic [23:0] XS = 24'h13579B;
    localparam logic [23:0] YS = 24'h2468AC;
    localparam logic [23:0] BS = 24'hA5A5A5;
    // ============================================================
    // Expectation helpers
    function automatic logic [23:0] rom_word(input logic [23:0] s, input int i);
        return s ^ 24'(i * 24'h010203);
    endfunction
    function automatic w256_t img256(input logic [23:0] s);
        for (int i = 0; i < 256; i++) begin
            img256[i] = rom_word(s, i);
        end
    endfunction
    function automatic w128_t img128(input logic [23:0] s);
        for (int i = 0; i < 128; i++) begin
            img128[i] = rom_word(s, i);
        end
    endfunction
    // ============================================================
    // Signals
    logic        clk, rst, ce, crst, start, fe, mv, mwr, mclr, boot, fv, mvv;
    logic [3:0]  dly;
    logic [15:0] a [2];
    logic        rd [2];
    logic        wr [2];
    logic [23:0] wd [2];
    wire  [23:0] rdat [2];
    wire         vld [2];
    logic [15:0] pa, ad, ma;
    logic [23:0] md, pd, d;
    logic [23:0] mem [2][512];
    logic [23:0] pm [1024];
    logic [15:0] q [$];
    int          fails, n_checks, cyc;

    always #20 clk = ~clk;

    dsp_core_memory_subsystem #(.CORE_ID(0), .X_ROM_IMAGE(img256(XS)), .Y_ROM_IMAGE(img256(YS)),
                                .BOOT_IMAGE(img128(BS))) dut (
        .i_clk(clk), .i_sys_rst(rst), .i_ce(ce),
        .i_x_address_bus(a[0]), .i_x_rd(rd[0]), .i_x_wr(wr[0]), .i_x_data_bus(wd[0]),
        .o_x_data_bus(rdat[0]), .o_x_data_valid(vld[0]),
        .i_y_address_bus(a[1]), .i_y_rd(rd[1]), .i_y_wr(wr[1]), .i_y_data_bus(wd[1]),
        .o_y_data_bus(rdat[1]), .o_y_data_valid(vld[1]),
        .i_fetch(fe), .i_program_address_bus(pa), .i_move_to_program_memory_instr(mv),
        .i_move_wr(mwr), .i_move_address(ma), .i_move_data(md), .o_program_data_bus(pd),
        .o_fetch_valid(fv), .o_move_valid(mvv), .i_core_reset_bit(crst), .i_mode_clear(mclr),
        .o_boot_mode(boot));

    core_loader_model loader (.i_clk(clk), .i_start(start), .i_delay(dly), .o_mode_clear(mclr));

    // ============================================================
    // Tasks: each request is set at a falling edge and answered by the next one
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic acc(input int sp, input logic r, input logic w, input logic [15:0] ad_i,
                       input logic [23:0] d_i, input logic ev, input logic [23:0] ed);
        a[sp] = ad_i;
        rd[sp] = r;
        wr[sp] = w;
        wd[sp] = d_i;
        // Request stays up until the next call or the caller drops it
        @(negedge clk);
        chk(24'(vld[sp]), 24'(ev), "data valid");
        if (ev) chk(rdat[sp], ed, "data word");
    endtask
    task automatic prg(input logic m, input logic w, input logic f, input logic [15:0] ad_i,
                       input logic [23:0] d_i, input logic ef, input logic em, input logic [23:0] ed);
        mv = m;
        mwr = w;
        fe = f;
        // The unused address carries noise so the port must pick the right source
        pa = m ? 16'($urandom) : ad_i;
        ma = m ? ad_i : 16'($urandom);
        md = d_i;
        @(negedge clk);
        chk(24'(fv), 24'(ef), "fetch valid");
        chk(24'(mvv), 24'(em), "move valid");
        if (ef || em) chk(pd, ed, "program word");
    endtask
    task automatic final_report();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 320 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            final_report();
        end
    end

    // ============================================================
    // Tests
    initial begin
        {clk, ce, rst} = 3'b011;
        {crst, start, fe, mv, mwr, dly, pa, ma, md} = '0;
        foreach (a[i]) begin
            {a[i], rd[i], wr[i], wd[i]} = '0;
        end
        void'($urandom(66));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk(24'(boot), 24'h1, "boot after reset");
        for (int sp = 0; sp < 2; sp++) begin
            for (int k = 0; k < 40; k++) begin
                ad = (k == 0) ? 16'h01FF : 16'($urandom_range(0, 511));
                d = 24'($urandom);
                mem[sp][ad[8:0]] = d;
                acc(sp, 1'b0, 1'b1, ad, d, 1'b0, 24'h0);
                acc(sp, 1'b1, 1'b0, ad, 24'h0, 1'b1, d);
            end
            for (int k = 0; k < 12; k++) begin
                ad = (k < 2) ? 16'(k * 255) : 16'($urandom_range(0, 255));
                acc(sp, 1'b1, 1'b0, 16'h0200 + ad, 24'h0, 1'b1, rom_word(sp ? YS : XS, int'(ad)));
            end
            acc(sp, 1'b0, 1'b1, 16'h0280, 24'hFFFFFF, 1'b0, 24'h0);
            acc(sp, 1'b1, 1'b0, 16'h0280, 24'h0, 1'b1, rom_word(sp ? YS : XS, 128));
            acc(sp, 1'b1, 1'b0, 16'h0300, 24'h0, 1'b0, 24'h0);
            ce = 1'b0;
            acc(sp, 1'b0, 1'b1, 16'h01FF, 24'h0, 1'b0, 24'h0);
            ce = 1'b1;
            acc(sp, 1'b1, 1'b0, 16'h01FF, 24'h0, 1'b1, mem[sp][511]);
            rd[sp] = 1'b0;
        end
        $display("test data spaces done");
        prg(1'b0, 1'b0, 1'b1, 16'hFF80, 24'h0, 1'b1, 1'b0, rom_word(BS, 0));
        prg(1'b0, 1'b0, 1'b1, 16'hFFFF, 24'h0, 1'b1, 1'b0, rom_word(BS, 127));
        prg(1'b0, 1'b0, 1'b1, 16'h0000, 24'h0, 1'b0, 1'b0, 24'h0);
        for (int k = 0; k < 30; k++) begin
            ad = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0005 : (k == 2) ? 16'h03FF : 16'($urandom_range(0, 1023));
            d = 24'($urandom);
            pm[ad[9:0]] = d;
            q.push_back(ad);
            prg(1'b1, 1'b1, 1'b0, ad, d, 1'b0, 1'b0, 24'h0);
        end
        foreach (q[i]) begin
            prg(1'b1, 1'b0, 1'b1, q[i], 24'h0, 1'b0, 1'b1, pm[q[i][9:0]]);
        end
        $display("test boot and move done");
        dly = 4'($urandom_range(0, 15));
        start = 1'b1;
        {mv, fe} = 2'b00;
        @(negedge clk);
        start = 1'b0;
        for (int i = 0; i < 40 && boot !== 1'b0; i++) begin
            @(negedge clk);
        end
        chk(24'(boot), 24'h0, "mode cleared");
        foreach (q[i]) begin
            prg(1'b0, 1'b0, 1'b1, q[i], 24'h0, 1'b1, 1'b0, pm[q[i][9:0]]);
        end
        prg(1'b0, 1'b0, 1'b1, 16'h0400, 24'h0, 1'b0, 1'b0, 24'h0);
        prg(1'b0, 1'b0, 1'b1, 16'hFF80, 24'h0, 1'b0, 1'b0, 24'h0);
        acc(0, 1'b0, 1'b1, 16'h0005, 24'h5A5A5A, 1'b0, 24'h0);
        acc(1, 1'b0, 1'b1, 16'h0005, 24'hA5A5A5, 1'b0, 24'h0);
        {wr[0], wr[1]} = 2'b00;
        prg(1'b0, 1'b0, 1'b1, 16'h0005, 24'h0, 1'b1, 1'b0, pm[5]);
        crst = 1'b1;
        @(negedge clk);
        crst = 1'b0;
        chk(24'(boot), 24'h1, "core reset mode");
        prg(1'b0, 1'b0, 1'b1, 16'h0005, 24'h0, 1'b0, 1'b0, 24'h0);
        $display("test mode done");
        final_report();
    end
endmodule
